// ==== gefds_map.vh ====
// gefds_map.vh: register offsets, field positions and reset values for the guest exit filter
// assumes inclusion by the filter modules; definitions only
`ifndef GEFDS_MAP_VH
`define GEFDS_MAP_VH

// register byte offsets on the apb window
`define GEFDS_OFF_CTRL 12'h000
`define GEFDS_OFF_PCW_MASK 12'h004
`define GEFDS_OFF_PCW_SHADOW 12'h008
`define GEFDS_OFF_EFCW_MASK 12'h00C
`define GEFDS_OFF_EFCW_SHADOW 12'h010
`define GEFDS_OFF_PF_MASK 12'h014
`define GEFDS_OFF_PF_MATCH 12'h018
`define GEFDS_OFF_EXC_BITMAP 12'h01C
`define GEFDS_OFF_TGT0 12'h020
`define GEFDS_OFF_TGT1 12'h024
`define GEFDS_OFF_TGT2 12'h028
`define GEFDS_OFF_TGT3 12'h02C
`define GEFDS_OFF_G_DBGCTL 12'h030
`define GEFDS_OFF_G_DBGMSR 12'h034
`define GEFDS_OFF_G_FLAGS 12'h038
`define GEFDS_OFF_G_PEND 12'h03C
`define GEFDS_OFF_STATUS 12'h040
`define GEFDS_OFF_PCW_LIVE 12'h044
`define GEFDS_OFF_EFCW_LIVE 12'h048
`define GEFDS_OFF_DBGCTL_LIVE 12'h04C
`define GEFDS_OFF_DBGMSR_LIVE 12'h050
`define GEFDS_OFF_EXIT_REASON 12'h054
`define GEFDS_OFF_PTB_LIVE 12'h058
`define GEFDS_OFF_FLAGS_LIVE 12'h05C

// control register fields
`define GEFDS_CTRL_DRMOVE_EXIT 0
`define GEFDS_CTRL_MSRBMP_EN 1
`define GEFDS_CTRL_ENTRY 2
`define GEFDS_CTRL_INJECT 3
`define GEFDS_CTRL_PF_INVERT 4
`define GEFDS_CTRL_TGT_CNT_LO 8
`define GEFDS_CTRL_TGT_CNT_HI 10

// exception vector of debug exceptions in the bitmap
`define GEFDS_VEC_DEBUG 1

// debug control msr branch trap bit, pending single step bit
`define GEFDS_BTF_BIT 1
`define GEFDS_BS_BIT 14

// trap flag position in the flags word
`define GEFDS_TF_BIT 8

// exit reason codes
`define GEFDS_RSN_NONE 8'h00
`define GEFDS_RSN_EXC 8'h01
`define GEFDS_RSN_TASK 8'h09
`define GEFDS_RSN_CR 8'h1C
`define GEFDS_RSN_DR 8'h1D
`define GEFDS_RSN_MSR_RD 8'h1F
`define GEFDS_RSN_MSR_WR 8'h20

// guest access kinds on the request port
`define GEFDS_K_PCW_RD 4'h1
`define GEFDS_K_PCW_WR 4'h2
`define GEFDS_K_EFCW_RD 4'h3
`define GEFDS_K_EFCW_WR 4'h4
`define GEFDS_K_PTB_WR 4'h5
`define GEFDS_K_PF 4'h6
`define GEFDS_K_DR 4'h7
`define GEFDS_K_TASK 4'h8
`define GEFDS_K_MSR_RD 4'h9
`define GEFDS_K_MSR_WR 4'hA
`define GEFDS_K_DBG 4'hB

// covered msr ranges of the bitmap
`define GEFDS_MSR_LO_END 32'h00001FFF
`define GEFDS_MSR_HI_BASE 32'hC0000000
`define GEFDS_MSR_HI_END 32'hC0001FFF
`define GEFDS_MSR_DBGCTL 32'h000001D9

`define GEFDS_ZERO32 32'h00000000
`define GEFDS_ONE1 1'b1
`define GEFDS_NTGT 4

`endif

// ==== gefds_tgt_match.v ====
// gefds_tgt_match.v: compares a page-table base load against the target list
// assumes targets and count are stable registers of the parent
`timescale 1ns/1ns
`include "gefds_map.vh"

module gefds_tgt_match (
   input wire [31:0] value,
   input wire [127:0] targets,
   input wire [2:0] count,
   output wire hit
);

   wire [`GEFDS_NTGT-1:0] hits;

   // one comparator per list entry, only entries below count are valid
   genvar gi;
   generate
      for (gi = 0; gi < `GEFDS_NTGT; gi = gi + 1) begin : g_cmp
         assign hits[gi] = (count > gi) && (targets[gi*32 +: 32] == value);
      end
   endgenerate

   assign hit = |hits;

endmodule

// ==== gefds_top.v ====
// gefds_top.v: guest exit filter with debug state save and restore, apb register slave
// assumes core presents one guest access per cycle on req_valid, synchronous to pclk
//
// Overview of operation
// - control word reads never exit
// - control word reads return the shadow
// - writes touching only guest bits pass
// - writes touching host bits exit
// - base loads matching a target pass
// - page faults filtered by mask and match
// - debug exit precedes debug register updates
// - debug register moves exit when enabled
// - every task switch exits
// - exit saves debug control and msr
// - entry loads debug control and msr
// - entry loads flags or pushes on inject
// - entry loads pending debug then delivers
// - pending state holds recognized undelivered exceptions
// - single step bit alone makes pending valid
// - clearing branch trap under block steps
// - setting branch trap under block suppresses traps
// - bitmap debug traps exit, not delivered
// - msr access exits without bitmap or outside ranges
//
// The APB slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`include "gefds_map.vh"

module gefds_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire req_valid,
   input wire [3:0] req_kind,
   input wire [31:0] req_data,
   input wire req_msr_bmp_hit,
   input wire dbg_blocked,
   output reg rsp_valid,
   output reg rsp_exit,
   output reg [31:0] rsp_data,
   output reg dbg_deliver,
   output reg flags_push
);

   // one-hot sequencer for entry
   localparam ST_RUN = 3'b001;
   localparam ST_ENTRY = 3'b010;
   localparam ST_DELIVER = 3'b100;

   // sequencer state
   reg [2:0] state_q, state_d;

   // hypervisor controls, masks, shadows and filters
   reg [31:0] ctrl_q, pcw_mask_q, pcw_shadow_q, efcw_mask_q, efcw_shadow_q;
   reg [31:0] pf_mask_q, pf_match_q, exc_bitmap_q;
   reg [127:0] tgt_q;

   // guest-state area of the control structure
   reg [31:0] g_dbgctl_q, g_dbgmsr_q, g_flags_q, g_pend_q;

   // live guest registers as the core holds them
   reg [31:0] pcw_live_q, efcw_live_q, dbgctl_live_q, dbgmsr_live_q, flags_live_q, pend_live_q, ptb_live_q;

   // last exit reason and running exit count
   reg [7:0] reason_q;
   reg [31:0] exit_cnt_q;

   // per-access decision, settled before the edge
   reg exit_d;
   reg [7:0] reason_d;
   reg [31:0] data_d;
   wire tgt_hit;

   // bus strobe and derived conditions
   wire wr_en = psel & penable & pwrite;
   wire in_run = state_q[0];
   wire pend_valid = pend_live_q[`GEFDS_BS_BIT];
   wire dbg_exc_exit = exc_bitmap_q[`GEFDS_VEC_DEBUG];
   // guest trap recognized this cycle, wins over a same-cycle clear
   wire dbg_set = in_run && req_valid && !exit_d && (req_kind == `GEFDS_K_DBG);
   // msr index inside a bitmap-covered range
   wire msr_in_range = (req_data <= `GEFDS_MSR_LO_END) ||
      ((req_data >= `GEFDS_MSR_HI_BASE) && (req_data <= `GEFDS_MSR_HI_END));

   // target list comparators
   gefds_tgt_match u_tgt (
      .value(req_data),
      .targets(tgt_q),
      .count(ctrl_q[`GEFDS_CTRL_TGT_CNT_HI:`GEFDS_CTRL_TGT_CNT_LO]),
      .hit(tgt_hit)
   );

   // exit decision per guest access
   always @* begin
      exit_d = 1'b0;
      reason_d = `GEFDS_RSN_NONE;
      data_d = `GEFDS_ZERO32;
      case (req_kind)
         `GEFDS_K_PCW_RD: begin
            data_d = pcw_shadow_q;
         end
         `GEFDS_K_EFCW_RD: begin
            data_d = efcw_shadow_q;
         end
         `GEFDS_K_PCW_WR: begin
            exit_d = |((req_data ^ pcw_live_q) & pcw_mask_q);
            reason_d = exit_d ? `GEFDS_RSN_CR : `GEFDS_RSN_NONE;
         end
         `GEFDS_K_EFCW_WR: begin
            exit_d = |((req_data ^ efcw_live_q) & efcw_mask_q);
            reason_d = exit_d ? `GEFDS_RSN_CR : `GEFDS_RSN_NONE;
         end
         `GEFDS_K_PTB_WR: begin
            exit_d = ~tgt_hit;
            reason_d = exit_d ? `GEFDS_RSN_CR : `GEFDS_RSN_NONE;
         end
         `GEFDS_K_PF: begin
            // match compare, sense flipped by the invert control
            exit_d = (((req_data & pf_mask_q) == pf_match_q) ^ ctrl_q[`GEFDS_CTRL_PF_INVERT]);
            reason_d = exit_d ? `GEFDS_RSN_EXC : `GEFDS_RSN_NONE;
         end
         `GEFDS_K_DR: begin
            exit_d = ctrl_q[`GEFDS_CTRL_DRMOVE_EXIT];
            reason_d = exit_d ? `GEFDS_RSN_DR : `GEFDS_RSN_NONE;
         end
         `GEFDS_K_TASK: begin
            exit_d = 1'b1;
            reason_d = `GEFDS_RSN_TASK;
         end
         `GEFDS_K_MSR_RD: begin
            exit_d = ~ctrl_q[`GEFDS_CTRL_MSRBMP_EN] | ~msr_in_range | req_msr_bmp_hit;
            reason_d = exit_d ? `GEFDS_RSN_MSR_RD : `GEFDS_RSN_NONE;
         end
         `GEFDS_K_MSR_WR: begin
            exit_d = ~ctrl_q[`GEFDS_CTRL_MSRBMP_EN] | ~msr_in_range | req_msr_bmp_hit;
            reason_d = exit_d ? `GEFDS_RSN_MSR_WR : `GEFDS_RSN_NONE;
         end
         `GEFDS_K_DBG: begin
            exit_d = dbg_exc_exit;
            reason_d = exit_d ? `GEFDS_RSN_EXC : `GEFDS_RSN_NONE;
         end
         default: begin
            exit_d = 1'b0;
         end
      endcase
   end

   // entry sequencer
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_RUN: begin
            if (wr_en && paddr == `GEFDS_OFF_CTRL && pwdata[`GEFDS_CTRL_ENTRY]) begin
               state_d = ST_ENTRY;
            end
         end
         ST_ENTRY: begin
            state_d = ST_DELIVER;
         end
         ST_DELIVER: begin
            state_d = ST_RUN;
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   // apb registers, live guest state, exit and entry effects
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // every register and output cleared, sequencer state set to ST_RUN
         state_q <= ST_RUN;
         ctrl_q <= `GEFDS_ZERO32;
         pcw_mask_q <= `GEFDS_ZERO32;
         pcw_shadow_q <= `GEFDS_ZERO32;
         efcw_mask_q <= `GEFDS_ZERO32;
         efcw_shadow_q <= `GEFDS_ZERO32;
         pf_mask_q <= `GEFDS_ZERO32;
         pf_match_q <= `GEFDS_ZERO32;
         exc_bitmap_q <= `GEFDS_ZERO32;
         tgt_q <= {`GEFDS_NTGT{`GEFDS_ZERO32}};
         g_dbgctl_q <= `GEFDS_ZERO32;
         g_dbgmsr_q <= `GEFDS_ZERO32;
         g_flags_q <= `GEFDS_ZERO32;
         g_pend_q <= `GEFDS_ZERO32;
         pcw_live_q <= `GEFDS_ZERO32;
         efcw_live_q <= `GEFDS_ZERO32;
         dbgctl_live_q <= `GEFDS_ZERO32;
         dbgmsr_live_q <= `GEFDS_ZERO32;
         flags_live_q <= `GEFDS_ZERO32;
         pend_live_q <= `GEFDS_ZERO32;
         ptb_live_q <= `GEFDS_ZERO32;
         reason_q <= `GEFDS_RSN_NONE;
         exit_cnt_q <= `GEFDS_ZERO32;
         rsp_valid <= 1'b0;
         rsp_exit <= 1'b0;
         rsp_data <= `GEFDS_ZERO32;
         dbg_deliver <= 1'b0;
         flags_push <= 1'b0;
      end else begin
         state_q <= state_d;
         // single-cycle pulses default low
         rsp_valid <= 1'b0;
         rsp_exit <= 1'b0;
         dbg_deliver <= 1'b0;
         flags_push <= 1'b0;
         // software writes; entry bit is a pulse, not stored
         if (wr_en) begin
            case (paddr)
               `GEFDS_OFF_CTRL: ctrl_q <= pwdata & ~(32'h00000001 << `GEFDS_CTRL_ENTRY);
               `GEFDS_OFF_PCW_MASK: pcw_mask_q <= pwdata;
               `GEFDS_OFF_PCW_SHADOW: pcw_shadow_q <= pwdata;
               `GEFDS_OFF_EFCW_MASK: efcw_mask_q <= pwdata;
               `GEFDS_OFF_EFCW_SHADOW: efcw_shadow_q <= pwdata;
               `GEFDS_OFF_PF_MASK: pf_mask_q <= pwdata;
               `GEFDS_OFF_PF_MATCH: pf_match_q <= pwdata;
               `GEFDS_OFF_EXC_BITMAP: exc_bitmap_q <= pwdata;
               `GEFDS_OFF_TGT0: tgt_q[31:0] <= pwdata;
               `GEFDS_OFF_TGT1: tgt_q[63:32] <= pwdata;
               `GEFDS_OFF_TGT2: tgt_q[95:64] <= pwdata;
               `GEFDS_OFF_TGT3: tgt_q[127:96] <= pwdata;
               `GEFDS_OFF_G_DBGCTL: g_dbgctl_q <= pwdata;
               `GEFDS_OFF_G_DBGMSR: g_dbgmsr_q <= pwdata;
               `GEFDS_OFF_G_FLAGS: g_flags_q <= pwdata;
               `GEFDS_OFF_G_PEND: g_pend_q <= pwdata;
               default: ;
            endcase
         end
         // entry: load debug state, flags (or push them when injecting) and pending exceptions
         if (state_q[1]) begin
            dbgctl_live_q <= g_dbgctl_q;
            dbgmsr_live_q <= g_dbgmsr_q;
            if (ctrl_q[`GEFDS_CTRL_INJECT]) begin
               flags_push <= 1'b1;
            end else begin
               flags_live_q <= g_flags_q;
            end
            pend_live_q <= g_pend_q;
         end
         // after entry completes, deliver a valid pending exception
         if (state_q[2] && pend_valid) begin
            dbg_deliver <= 1'b1;
            pend_live_q <= `GEFDS_ZERO32;
         end
         // guest access while running
         if (in_run && req_valid) begin
            rsp_valid <= 1'b1;
            rsp_exit <= exit_d;
            rsp_data <= data_d;
            if (exit_d) begin
               // debug state saved before any debug register update, live words untouched
               g_dbgctl_q <= dbgctl_live_q;
               g_dbgmsr_q <= dbgmsr_live_q;
               g_pend_q <= pend_live_q;
               reason_q <= reason_d;
               exit_cnt_q <= exit_cnt_q + 32'h00000001;
            end else begin
               case (req_kind)
                  `GEFDS_K_PCW_WR: pcw_live_q <= req_data;
                  `GEFDS_K_EFCW_WR: efcw_live_q <= req_data;
                  `GEFDS_K_PTB_WR: ptb_live_q <= req_data;
                  `GEFDS_K_DBG: begin
                     // recognized trap becomes pending; status bit set
                     pend_live_q[`GEFDS_BS_BIT] <= `GEFDS_ONE1;
                  end
                  `GEFDS_K_MSR_WR: begin
                     if (req_data == `GEFDS_MSR_DBGCTL) begin
                        dbgmsr_live_q <= dbgmsr_live_q;
                     end
                  end
                  default: ;
               endcase
            end
         end
         // passed debug register move updates the debug control word
         if (in_run && req_valid && !exit_d && req_kind == `GEFDS_K_DR) begin
            dbgctl_live_q <= req_data;
         end
         // emulated msr write of branch trap under blocked trap flag
         if (in_run && wr_en && paddr == `GEFDS_OFF_DBGMSR_LIVE) begin
            dbgmsr_live_q <= pwdata;
            if (flags_live_q[`GEFDS_TF_BIT] && dbg_blocked) begin
               if (dbgmsr_live_q[`GEFDS_BTF_BIT] && !pwdata[`GEFDS_BTF_BIT]) begin
                  pend_live_q[`GEFDS_BS_BIT] <= 1'b1;
               end else if (!dbgmsr_live_q[`GEFDS_BTF_BIT] && pwdata[`GEFDS_BTF_BIT] && !dbg_set) begin
                  pend_live_q[`GEFDS_BS_BIT] <= 1'b0;
               end
            end
         end
      end
   end

   // apb read mux and zero-wait answer
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= `GEFDS_ZERO32;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel & ~penable;
         pslverr <= 1'b0;
         if (psel && !penable && !pwrite) begin
            case (paddr)
               `GEFDS_OFF_CTRL: prdata <= ctrl_q;
               `GEFDS_OFF_PCW_MASK: prdata <= pcw_mask_q;
               `GEFDS_OFF_PCW_SHADOW: prdata <= pcw_shadow_q;
               `GEFDS_OFF_EFCW_MASK: prdata <= efcw_mask_q;
               `GEFDS_OFF_EFCW_SHADOW: prdata <= efcw_shadow_q;
               `GEFDS_OFF_PF_MASK: prdata <= pf_mask_q;
               `GEFDS_OFF_PF_MATCH: prdata <= pf_match_q;
               `GEFDS_OFF_EXC_BITMAP: prdata <= exc_bitmap_q;
               `GEFDS_OFF_TGT0: prdata <= tgt_q[31:0];
               `GEFDS_OFF_TGT1: prdata <= tgt_q[63:32];
               `GEFDS_OFF_TGT2: prdata <= tgt_q[95:64];
               `GEFDS_OFF_TGT3: prdata <= tgt_q[127:96];
               `GEFDS_OFF_G_DBGCTL: prdata <= g_dbgctl_q;
               `GEFDS_OFF_G_DBGMSR: prdata <= g_dbgmsr_q;
               `GEFDS_OFF_G_FLAGS: prdata <= g_flags_q;
               `GEFDS_OFF_G_PEND: prdata <= g_pend_q;
               `GEFDS_OFF_STATUS: prdata <= {exit_cnt_q[28:0], state_q};
               `GEFDS_OFF_PCW_LIVE: prdata <= pcw_live_q;
               `GEFDS_OFF_EFCW_LIVE: prdata <= efcw_live_q;
               `GEFDS_OFF_DBGCTL_LIVE: prdata <= dbgctl_live_q;
               `GEFDS_OFF_DBGMSR_LIVE: prdata <= dbgmsr_live_q;
               `GEFDS_OFF_EXIT_REASON: prdata <= {24'h000000, reason_q};
               `GEFDS_OFF_PTB_LIVE: prdata <= ptb_live_q;
               `GEFDS_OFF_FLAGS_LIVE: prdata <= flags_live_q;
               default: begin
                  prdata <= `GEFDS_ZERO32;
                  pslverr <= 1'b1;
               end
            endcase
         end else if (psel && !penable) begin
            prdata <= `GEFDS_ZERO32;
            pslverr <= ~(paddr <= `GEFDS_OFF_FLAGS_LIVE && paddr[1:0] == 2'b00);
         end
      end
   end

endmodule

// ==== gefds_top_assertions.sv ====
// gefds_top_assertions.sv: port-level checks for the guest exit filter
// assumes bind into gefds_top, one pclk domain, presetn active low
`timescale 1ns/1ns
`include "gefds_map.vh"
module gefds_chk (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire pready,
   input wire pslverr,
   input wire req_valid,
   input wire [3:0] req_kind,
   input wire [31:0] req_data,
   input wire rsp_valid,
   input wire rsp_exit,
   input wire [31:0] rsp_data,
   input wire dbg_deliver,
   input wire flags_push
);
   // entry strobe and access classes
   wire ent = psel && penable && pwrite && paddr == `GEFDS_OFF_CTRL && pwdata[`GEFDS_CTRL_ENTRY];
   wire inj = ent && pwdata[`GEFDS_CTRL_INJECT];
   wire rdk = req_kind == `GEFDS_K_PCW_RD || req_kind == `GEFDS_K_EFCW_RD;
   wire msk = req_kind == `GEFDS_K_MSR_RD || req_kind == `GEFDS_K_MSR_WR;
   wire far = req_data > `GEFDS_MSR_LO_END && (req_data < `GEFDS_MSR_HI_BASE || req_data > `GEFDS_MSR_HI_END);
   default clocking dc @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup; psel && !penable; endsequence
   sequence s_access; psel && penable && pready; endsequence
   // bus answer timing
   AST_APB_ANSWER: assert property (s_setup |=> s_access) else $error("apb not ready after setup");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("slave error outside access");
   // guest response relations
   AST_RSP_AFTER_REQ: assert property (rsp_valid |-> $past(req_valid)) else $error("response without request");
   AST_CW_READ_STAYS: assert property (req_valid && rdk |=> !rsp_valid || !rsp_exit)
      else $error("control word read exited");
   AST_TASK_EXITS: assert property (req_valid && req_kind == `GEFDS_K_TASK |=> !rsp_valid || rsp_exit)
      else $error("task switch did not exit");
   AST_MSR_FAR_EXITS: assert property (req_valid && msk && far |=> !rsp_valid || rsp_exit)
      else $error("uncovered msr access did not exit");
   AST_DATA_ZERO: assert property (rsp_valid && !$past(rdk) |-> rsp_data == 32'h00000000)
      else $error("non-read response data not zero");
   // entry side effects
   AST_PUSH_ON_INJECT: assert property (flags_push |-> $past(inj) || $past(inj, 2))
      else $error("flags push without injecting entry");
   AST_DELIVER_AFTER_ENTRY: assert property (dbg_deliver |-> $past(ent, 2) || $past(ent, 3))
      else $error("debug delivery without entry");
endmodule
bind gefds_top gefds_chk u_gefds_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .req_valid(req_valid), .req_kind(req_kind), .req_data(req_data), .rsp_valid(rsp_valid),
   .rsp_exit(rsp_exit), .rsp_data(rsp_data), .dbg_deliver(dbg_deliver), .flags_push(flags_push));

// ==== tb.sv ====
// tb.sv: self-checking bench for the guest exit filter
// assumes gefds_top and the offsets and codes of the map header
`timescale 1ns/1ns
`include "gefds_map.vh"
module tb;
   reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg [11:0] paddr = 12'h000;
   reg [31:0] pwdata = 32'h00000000, req_data = 32'h00000000;
   reg req_valid = 1'b0, req_msr_bmp_hit = 1'b0, dbg_blocked = 1'b0;
   reg [3:0] req_kind = 4'h0, kw;
   wire [31:0] prdata, rsp_data;
   wire pready, pslverr, rsp_valid, rsp_exit, dbg_deliver, flags_push;
   integer err_count = 0, samples_checked = 0, seed = 32'hDF63BCD3, n_push = 0, n_dlv = 0, i;
   reg [31:0] r, m, v, a, b;
   reg [11:0] al, am;
   reg e;
   always #50 pclk = ~pclk;
   // counts entry pulses
   always @(posedge pclk) begin
      if (flags_push === 1'b1) n_push <= n_push + 1;
      if (dbg_deliver === 1'b1) n_dlv <= n_dlv + 1;
   end
   gefds_top u_gefds_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .req_valid(req_valid), .req_kind(req_kind), .req_data(req_data), .req_msr_bmp_hit(req_msr_bmp_hit),
      .dbg_blocked(dbg_blocked), .rsp_valid(rsp_valid), .rsp_exit(rsp_exit), .rsp_data(rsp_data),
      .dbg_deliver(dbg_deliver), .flags_push(flags_push));
   task conclude; begin
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   end endtask
   task chk(input [31:0] s, input [31:0] x); begin
      samples_checked = samples_checked + 1;
      if (s !== x) begin
         err_count = err_count + 1;
         $display("[FAIL] %0t seen %h expected %h", $time, s, x);
      end
   end endtask
   // one apb transfer, held until pready
   task apb(input w, input [11:0] ad, input [31:0] d); integer k; begin
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= ad; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge pclk); k = k + 1; end while (pready !== 1'b1 && k < 16);
      if (k == 16) begin err_count = err_count + 1; conclude; end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   end endtask
   task wr(input [11:0] ad, input [31:0] d); apb(1'b1, ad, d); endtask
   task rd(input [11:0] ad); apb(1'b0, ad, 32'h00000000); endtask
   task rdx(input [11:0] ad, input [31:0] x); begin rd(ad); chk(r, x); end endtask
   // one guest access, checks the exit decision
   task rqx(input [3:0] k, input [31:0] d, input x); integer t; begin
      @(posedge pclk);
      req_valid <= 1'b1; req_kind <= k; req_data <= d;
      @(posedge pclk);
      req_valid <= 1'b0;
      t = 0;
      do begin @(posedge pclk); t = t + 1; end while (rsp_valid !== 1'b1 && t < 4);
      if (t == 4) begin err_count = err_count + 1; conclude; end
      r = rsp_data;
      chk(rsp_exit, x);
   end endtask
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      // unmapped place refused
      rd(12'hFFC);
      chk(e, 1'b1);
      chk(r, 32'h00000000);
      // shadows and masked writes for both control words
      for (i = 0; i < 2; i = i + 1) begin
         al = i ? `GEFDS_OFF_EFCW_LIVE : `GEFDS_OFF_PCW_LIVE;
         am = i ? `GEFDS_OFF_EFCW_MASK : `GEFDS_OFF_PCW_MASK;
         kw = i ? `GEFDS_K_EFCW_WR : `GEFDS_K_PCW_WR;
         v = $random(seed);
         wr(i ? `GEFDS_OFF_EFCW_SHADOW : `GEFDS_OFF_PCW_SHADOW, v);
         rqx(i ? `GEFDS_K_EFCW_RD : `GEFDS_K_PCW_RD, 32'h00000000, 1'b0);
         chk(r, v);
         m = $random(seed) | 32'h00000001;
         wr(am, m);
         rd(al);
         v = r ^ ($random(seed) & ~m);
         rqx(kw, v, 1'b0);
         rdx(al, v);
         rqx(kw, v ^ (m & -m), 1'b1);
         rdx(al, v);
      end
      // target list of two, third entry beyond the count
      a = $random(seed);
      wr(`GEFDS_OFF_TGT0, a);
      wr(`GEFDS_OFF_TGT1, a ^ 32'h00001000);
      wr(`GEFDS_OFF_TGT2, a ^ 32'h00002000);
      wr(`GEFDS_OFF_CTRL, 32'h00000200);
      rqx(`GEFDS_K_PTB_WR, a, 1'b0);
      rqx(`GEFDS_K_PTB_WR, a ^ 32'h00001000, 1'b0);
      rqx(`GEFDS_K_PTB_WR, a ^ 32'h00002000, 1'b1);
      // page fault filter, plain and inverted sense
      m = $random(seed) | 32'h00000001;
      wr(`GEFDS_OFF_PF_MASK, m);
      wr(`GEFDS_OFF_PF_MATCH, a & m);
      for (i = 0; i < 2; i = i + 1) begin
         wr(`GEFDS_OFF_CTRL, i << 4);
         rqx(`GEFDS_K_PF, a | ~m, ~i[0]);
         rqx(`GEFDS_K_PF, a ^ m, i[0]);
      end
      // debug moves, task switches and msr accesses under every control pair
      for (i = 0; i < 4; i = i + 1) begin
         wr(`GEFDS_OFF_CTRL, i);
         req_msr_bmp_hit <= i[0];
         rqx(`GEFDS_K_DR, $random(seed), i[0]);
         rqx(`GEFDS_K_TASK, 32'h00000000, 1'b1);
         rqx(`GEFDS_K_MSR_RD, 32'h00000010, ~i[1] | i[0]);
         rqx(`GEFDS_K_MSR_WR, 32'hC0000010, ~i[1] | i[0]);
         rqx(`GEFDS_K_MSR_RD, 32'h40000000, 1'b1);
      end
      // debug trap with bitmap exits before any debug state changes
      b = $random(seed) & ~32'h00004002;
      wr(`GEFDS_OFF_CTRL, 32'h00000000);
      rqx(`GEFDS_K_DR, a, 1'b0);
      wr(`GEFDS_OFF_DBGMSR_LIVE, b);
      wr(`GEFDS_OFF_EXC_BITMAP, 32'h00000002);
      rqx(`GEFDS_K_DBG, 32'h00000000, 1'b1);
      rd(`GEFDS_OFF_EXIT_REASON);
      chk(r[7:0], `GEFDS_RSN_EXC);
      rdx(`GEFDS_OFF_DBGCTL_LIVE, a);
      rdx(`GEFDS_OFF_G_DBGCTL, a);
      rdx(`GEFDS_OFF_G_DBGMSR, b);
      rd(`GEFDS_OFF_G_PEND);
      chk(r[14], 1'b0);
      wr(`GEFDS_OFF_EXC_BITMAP, 32'h00000000);
      rqx(`GEFDS_K_DBG, 32'h00000000, 1'b0);
      rqx(`GEFDS_K_TASK, 32'h00000000, 1'b1);
      rd(`GEFDS_OFF_G_PEND);
      chk(r[14], 1'b1);
      // entry with trap flag set, loads state and delivers pending step
      wr(`GEFDS_OFF_G_FLAGS, 32'h00000100);
      wr(`GEFDS_OFF_G_DBGCTL, ~a);
      wr(`GEFDS_OFF_CTRL, 32'h00000004);
      repeat (5) @(posedge pclk);
      chk(n_dlv, 1);
      chk(n_push, 0);
      rdx(`GEFDS_OFF_DBGCTL_LIVE, ~a);
      rdx(`GEFDS_OFF_DBGMSR_LIVE, b);
      rdx(`GEFDS_OFF_FLAGS_LIVE, 32'h00000100);
      // branch trap writes while blocked
      dbg_blocked <= 1'b1;
      wr(`GEFDS_OFF_DBGMSR_LIVE, 32'h00000002);
      wr(`GEFDS_OFF_DBGMSR_LIVE, 32'h00000000);
      rqx(`GEFDS_K_TASK, 32'h00000000, 1'b1);
      rd(`GEFDS_OFF_G_PEND);
      chk(r[14], 1'b1);
      wr(`GEFDS_OFF_DBGMSR_LIVE, 32'h00000002);
      rqx(`GEFDS_K_TASK, 32'h00000000, 1'b1);
      rd(`GEFDS_OFF_G_PEND);
      chk(r[14], 1'b0);
      // injecting entry, step pending with trap flag clear and branch trap set
      dbg_blocked <= 1'b0;
      wr(`GEFDS_OFF_G_FLAGS, 32'h00000000);
      wr(`GEFDS_OFF_G_DBGMSR, 32'h00000002);
      wr(`GEFDS_OFF_G_PEND, 32'h00004000);
      wr(`GEFDS_OFF_CTRL, 32'h0000000C);
      repeat (5) @(posedge pclk);
      chk(n_push, 1);
      rdx(`GEFDS_OFF_FLAGS_LIVE, 32'h00000100);
      chk(n_dlv, 2);
      conclude;
   end
endmodule
